/* File: orm_core.sv */
// Bus-attached unit for literal OR, file OR, file move and pointer load.
`timescale 1ns/10ps

module orm_core
  import orm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output orm_mem_t         o_mem,
  input  wire logic [7:0]  i_mem_rdata
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  orm_state_t  state_reg;
  orm_dec_t    dec_reg;
  logic        second_reg;
  logic        lo_ok_reg;
  logic [7:0]  lo_reg;
  logic [7:0]  acc_reg;
  logic [3:0]  bank_reg;
  logic        ext_reg;
  logic        sign_reg;
  logic        zero_reg;
  logic [7:0]  result_reg;
  logic [3:0]  phi_reg [3];
  logic [7:0]  plo_reg [3];
  logic        dp_valid_reg;
  logic        dp_write_reg;
  logic        dp_hit_reg;
  logic [7:0]  dp_addr_reg;
  logic        busy;
  logic        stall;
  logic        wr_en;
  logic        go;
  logic        file_op;
  logic        flag_op;
  logic [11:0] ex_addr;
  logic [7:0]  ex_result;
  logic [1:0]  ex_flags;
  logic [11:0] ptr2;

  assign ptr2    = {phi_reg[2], plo_reg[2]};
  assign file_op = (dec_reg.op == OP_IORF) || (dec_reg.op == OP_MOVE);
  assign flag_op = file_op || (dec_reg.op == OP_IORL);

  orm_exec u_exec (
    .i_dec    (dec_reg),
    .i_acc    (acc_reg),
    .i_bank   (bank_reg),
    .i_ptr2   (ptr2),
    .i_ext_en (ext_reg),
    .i_rdata  (i_mem_rdata),
    .o_addr   (ex_addr),
    .o_result (ex_result),
    .o_flags  (ex_flags)
  );

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  // Address phase is held until the data phase completes; a stalled write
  // keeps hready low, so the capture below holds as well.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_hit_reg   <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else if (i_hready) begin
      dp_valid_reg <= i_hsel && i_htrans[1];
      dp_write_reg <= i_hwrite;
      dp_hit_reg   <= (i_haddr[31:8] == 24'h000000);
      dp_addr_reg  <= i_haddr[7:0];
    end
  end

  // Writes wait while an opcode is in its four phases, so software can never
  // race the unit on the accumulator, bank or pointers.
  assign busy        = (state_reg != S_IDLE) && (state_reg != S_WAIT);
  assign stall       = dp_valid_reg && dp_write_reg && busy;
  assign o_hreadyout = !stall;
  assign o_hresp     = 1'b0;
  assign wr_en       = dp_valid_reg && dp_write_reg && dp_hit_reg && !stall;
  assign go          = wr_en && (dp_addr_reg == OFS_INSTR);

  // Read data muxes the registers themselves; unmapped words read zero.
  always_comb begin
    o_hrdata = 32'h00000000;
    if (dp_valid_reg && !dp_write_reg && dp_hit_reg) begin
      unique case (dp_addr_reg)
        OFS_CTRL:   o_hrdata[CTRL_EXT_BIT] = ext_reg;
        OFS_STATUS: begin
          o_hrdata[STAT_BUSY_BIT] = busy;
          o_hrdata[STAT_WAIT_BIT] = (state_reg == S_WAIT);
          o_hrdata[STAT_ZERO_BIT] = zero_reg;
          o_hrdata[STAT_SIGN_BIT] = sign_reg;
        end
        OFS_ACC:    o_hrdata[7:0]  = acc_reg;
        OFS_BANK:   o_hrdata[3:0]  = bank_reg;
        OFS_PTR0:   o_hrdata[11:0] = {phi_reg[0], plo_reg[0]};
        OFS_PTR1:   o_hrdata[11:0] = {phi_reg[1], plo_reg[1]};
        OFS_PTR2:   o_hrdata[11:0] = ptr2;
        default:    o_hrdata = 32'h00000000;
      endcase
    end
  end

  // Configuration: extended set enable and bank selector.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ext_reg  <= 1'b0;
      bank_reg <= BANK_RST;
    end else if (wr_en && dp_addr_reg == OFS_CTRL) begin
      ext_reg <= i_hwdata[CTRL_EXT_BIT];
    end else if (wr_en && dp_addr_reg == OFS_BANK) begin
      bank_reg <= i_hwdata[3:0];
    end
  end

  // ==========================================================================
  // Phase sequencer
  // ==========================================================================
  // Four phases per word.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE:  if (go) state_reg <= S_Q1;
        S_WAIT:  if (go) state_reg <= S_Q1;
        S_Q1:    state_reg <= S_Q2;
        S_Q2:    state_reg <= S_Q3;
        S_Q3:    state_reg <= S_Q4;
        S_Q4:    state_reg <= (dec_reg.op == OP_LDP && !second_reg) ?
                              S_WAIT : S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Instruction capture; the second word of a pointer load keeps the first
  // word's decode and only brings the low byte.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dec_reg    <= '0;
      second_reg <= 1'b0;
      lo_ok_reg  <= 1'b0;
      lo_reg     <= 8'h00;
    end else if (go && state_reg == S_IDLE) begin
      dec_reg    <= orm_decode(i_hwdata[15:0]);
      second_reg <= 1'b0;
    end else if (go && state_reg == S_WAIT) begin
      second_reg <= 1'b1;
      lo_ok_reg  <= (i_hwdata[15:8] == OPC_LDP_W2);
      lo_reg     <= i_hwdata[7:0];
    end
  end

  // ==========================================================================
  // Operand read and write-back to file memory
  // ==========================================================================
  // Read strobe is visible in the read phase, data returns one cycle later;
  // the write strobe is visible in the write phase.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_mem <= '0;
    end else begin
      o_mem.rd <= (state_reg == S_Q1) && file_op;
      o_mem.wr <= 1'b0;
      if (state_reg == S_Q1) begin
        o_mem.addr <= ex_addr;
      end
      if (state_reg == S_Q3 && file_op && dec_reg.dest) begin
        o_mem.wr    <= 1'b1;
        o_mem.wdata <= ex_result;
      end
    end
  end

  // Result latched at the end of processing.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      result_reg <= 8'h00;
    end else if (state_reg == S_Q3) begin
      result_reg <= ex_result;
    end
  end

  // ==========================================================================
  // Accumulator and flags
  // ==========================================================================
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      acc_reg <= ACC_RST;
    end else if (state_reg == S_Q4 && (dec_reg.op == OP_IORL ||
                 (file_op && !dec_reg.dest))) begin
      acc_reg <= result_reg;
    end else if (wr_en && dp_addr_reg == OFS_ACC) begin
      acc_reg <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sign_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (state_reg == S_Q4 && flag_op) begin
      {sign_reg, zero_reg} <= orm_flags(result_reg);
    end
  end

  // ==========================================================================
  // Indirect pointers
  // ==========================================================================
  // Operand picks the pointer.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 3; i++) begin
        phi_reg[i] <= PHI_RST;
        plo_reg[i] <= PLO_RST;
      end
    end else if (state_reg == S_Q4 && dec_reg.op == OP_LDP &&
                 dec_reg.pidx <= PTR_LAST) begin
      if (!second_reg) begin
        phi_reg[dec_reg.pidx] <= dec_reg.khi;
      end else if (lo_ok_reg) begin
        plo_reg[dec_reg.pidx] <= lo_reg;
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_litor_acc: assert property (
    (state_reg == S_Q1 && dec_reg.op == OP_IORL) |=> ##3
    acc_reg == ($past(acc_reg, 3) | $past(dec_reg.faddr, 3)))
    else $error("Literal OR gave a wrong accumulator.");

  a_fileor_acc: assert property (
    (state_reg == S_Q3 && dec_reg.op == OP_IORF && !dec_reg.dest) |=> ##1
    acc_reg == ($past(acc_reg, 2) | $past(i_mem_rdata, 2)))
    else $error("File OR gave a wrong accumulator.");

  a_dest_file: assert property (
    (state_reg == S_Q3 && file_op && dec_reg.dest) |=>
    o_mem.wr && o_mem.wdata == $past(ex_result) ##1 $stable(acc_reg))
    else $error("File target not written or accumulator changed.");

  a_access_addr: assert property (
    (state_reg == S_Q1 && file_op && !dec_reg.bank_sel && !ext_reg) |=>
    o_mem.rd && o_mem.addr == (($past(dec_reg.faddr) <= ACCESS_SPLIT) ?
    {4'h0, $past(dec_reg.faddr)} : {ACCESS_HIGH, $past(dec_reg.faddr)}))
    else $error("Access bank address wrong.");

  a_bank_addr: assert property (
    (state_reg == S_Q1 && file_op && dec_reg.bank_sel) |=>
    o_mem.rd && o_mem.addr == {$past(bank_reg), $past(dec_reg.faddr)})
    else $error("Banked address wrong.");

  a_index_addr: assert property (
    (state_reg == S_Q1 && file_op && !dec_reg.bank_sel && ext_reg &&
     dec_reg.faddr <= ACCESS_SPLIT) |=>
    o_mem.addr == $past(ptr2) + {4'h0, $past(dec_reg.faddr)})
    else $error("Indexed offset address wrong.");

  a_ptr_high: assert property (
    (state_reg == S_Q4 && dec_reg.op == OP_LDP && !second_reg &&
     dec_reg.pidx <= PTR_LAST) |=>
    phi_reg[dec_reg.pidx] == dec_reg.khi && state_reg == S_WAIT)
    else $error("Pointer high part not loaded.");

  a_ptr_low: assert property (
    (state_reg == S_Q4 && dec_reg.op == OP_LDP && second_reg && lo_ok_reg &&
     dec_reg.pidx <= PTR_LAST) |=>
    plo_reg[dec_reg.pidx] == lo_reg && state_reg == S_IDLE)
    else $error("Pointer low byte not loaded.");

  a_ptr_flags: assert property (
    (state_reg == S_Q1 && dec_reg.op == OP_LDP) |=>
    $stable({sign_reg, zero_reg}) [*4])
    else $error("Pointer load touched the flags.");

  a_phase_order: assert property (
    (state_reg == S_Q1) |=> state_reg == S_Q2 ##1 state_reg == S_Q3
    ##1 state_reg == S_Q4)
    else $error("Phase order broken.");

  a_flag_value: assert property (
    (state_reg == S_Q4 && flag_op) |=>
    sign_reg == $past(result_reg[7]) &&
    zero_reg == ($past(result_reg) == 8'h00))
    else $error("Sign or zero flag wrong.");

  a_move_copy: assert property (
    (state_reg == S_Q3 && dec_reg.op == OP_MOVE) |=>
    result_reg == $past(i_mem_rdata))
    else $error("Move did not copy the read value.");

  c_litor: cover property (state_reg == S_Q4 && dec_reg.op == OP_IORL);
  c_file_wb: cover property (o_mem.wr);
  c_ptr_done: cover property (state_reg == S_Q4 && second_reg && lo_ok_reg);
  c_indexed: cover property (state_reg == S_Q1 && file_op && ext_reg &&
                             !dec_reg.bank_sel);

endmodule : orm_core

/* File: orm_core_tb.sv */
// Self-checking testbench of the OR, move and pointer-load unit.
`timescale 1ns/10ps

module orm_core_tb
  import orm_pkg::*;
();
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  orm_mem_t    mem_if;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem [0:4095];
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  int          cyc;
  int          rd_cyc;
  int          n_errors;
  int          num_checks;
  logic [31:0] seed;
  logic [7:0]  e_acc;
  logic [1:0]  e_flg;
  logic [3:0]  e_bank;
  logic        e_ext;
  logic [11:0] e_ptr [0:2];

  orm_core orm_core_inst (
    .i_clk_sys   (clk_sys),
    .i_rst_n     (rst_n),
    .i_hsel      (hsel),
    .i_haddr     (haddr),
    .i_htrans    (htrans),
    .i_hwrite    (hwrite),
    .i_hsize     (hsize),
    .i_hwdata    (hwdata),
    .i_hready    (hreadyout),
    .o_hrdata    (hrdata),
    .o_hreadyout (hreadyout),
    .o_hresp     (hresp),
    .o_mem       (mem_if),
    .i_mem_rdata (mem_rdata)
  );

  // Free-running system clock, 8 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Checking helpers and expectation functions
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors = n_errors + 1;
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Xorshift source so every run replays the same stimulus.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [1:0] flg(input logic [7:0] r);
    return {r[7], r == 8'h00};
  endfunction : flg

  function automatic logic [31:0] st(input logic w);
    return {28'h0, e_flg, w, 1'b0};
  endfunction : st

  // Operand address the way the addressing modes resolve it.
  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (a) return {e_bank, f};
    if (f <= ACCESS_SPLIT) return e_ext ? e_ptr[2] + {4'h0, f} : {4'h0, f};
    return {ACCESS_HIGH, f};
  endfunction : ea

  // File memory: data lands the cycle after the strobe and is not held after.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (mem_if.rd) begin
      mem_rdata <= mem[mem_if.addr];
      rd_addr   <= mem_if.addr;
      rd_cyc    <= cyc;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_if.wr) begin
      mem[mem_if.addr] <= mem_if.wdata;
      wr_addr          <= mem_if.addr;
      chk("write phase", 32'd2, 32'(cyc - rd_cyc)); // phase order
    end
  end

  // ==========================================================================
  // Bus master tasks
  // ==========================================================================
  // Ready is looked at mid-cycle, where it equals what the next edge samples.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 20) chk("hready wait", 32'd0, 32'd1);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    // Read data and response are taken at the edge that ends the data phase.
    @(posedge clk_sys);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask : rdchk

  // Launches one word and polls until the core leaves its busy phases.
  task automatic op(input logic [15:0] w);
    logic [31:0] r;
    int          k;
    wr(OFS_INSTR, {16'h0, w});
    k = 0;
    r = 32'h1;
    while (r[STAT_BUSY_BIT] !== 1'b0 && k < 20) begin
      bus(1'b0, OFS_STATUS, 32'h0, r);
      k++;
    end
    if (k == 20) chk("idle wait", 32'd0, 32'd1);
  endtask : op

  task automatic lit(input logic [7:0] k);
    e_acc = e_acc | k;
    e_flg = flg(e_acc);
    op({OPC_OR_LIT, k});
  endtask : lit

  // Watchdog: far beyond the roughly one thousand cycles the sequence needs.
  initial begin
    #200000;
    n_errors = n_errors + 1;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] r;
    logic [11:0] k12;
    logic [11:0] adr;
    logic [7:0]  f;
    logic [7:0]  m;
    logic [7:0]  res;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mem_rdata = 8'h00;
    cyc = 0;
    rd_cyc = 0;
    n_errors = 0;
    num_checks = 0;
    seed = 32'hab6a88c2;
    e_acc = 8'h00;
    e_flg = 2'h0;
    e_bank = 4'h0;
    e_ext = 1'b0;
    for (int i = 0; i < 3; i++) e_ptr[i] = 12'h000;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ {2{4'(i >> 8)}};
    rst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Every register after reset, then an unmapped place that ignores writes.
    for (int i = 0; i < 9; i++) rdchk("reset", (i < 8) ? 8'(4 * i) : 8'h40, 0);
    wr(8'h40, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h40, 32'h0);
    // Literal OR, zero result, then two words back to back with a stall.
    wr(OFS_ACC, 32'h9A);
    e_acc = 8'h9A;
    lit(8'h35);
    rdchk("acc", OFS_ACC, 32'hBF); // or result
    rdchk("status", OFS_STATUS, st(1'b0)); // sign flag
    wr(OFS_ACC, 32'h00);
    e_acc = 8'h00;
    lit(8'h00);
    rdchk("status", OFS_STATUS, st(1'b0)); // zero flag
    wr(OFS_INSTR, {16'h0, OPC_OR_LIT, 8'h01});
    e_acc = 8'h01;
    lit(8'h40);
    rdchk("acc", OFS_ACC, {24'h0, e_acc}); // stalled word
    // Sign is set first, so a pointer load that disturbs the flags shows.
    lit(8'h80);
    // Pointer loads: high part at the first word, low byte at the second.
    for (int p = 0; p < 3; p++) begin
      k12 = rnd() >> 20;
      op({OPC_LDP_W1, 2'b00, 2'(p), k12[11:8]});
      rdchk("status", OFS_STATUS, st(1'b1)); // second word due
      rdchk("hi", OFS_PTR0 + 8'(4 * p), {k12[11:8], e_ptr[p][7:0]});
      op({OPC_LDP_W2, k12[7:0]});
      e_ptr[p] = k12;
      rdchk("status", OFS_STATUS, st(1'b0)); // flags kept
    end
    // Operand 3 names no pointer: both words run and nothing is loaded.
    op({OPC_LDP_W1, 2'b00, 2'h3, 4'hF}); // no fourth pointer
    op({OPC_LDP_W2, 8'hAA}); // no fourth pointer
    for (int p = 0; p < 3; p++) begin
      rdchk("ptr", OFS_PTR0 + 8'(4 * p), e_ptr[p]); // pointer
    end
    // Random file OR and move, boundary addresses first.
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      f = (i < 4) ? 8'(32'h5F6000FF >> (24 - 8 * i)) : r[7:0];
      e_ext = r[11];
      e_bank = r[15:12];
      e_acc = r[23:16];
      wr(OFS_CTRL, {31'h0, e_ext});
      wr(OFS_BANK, {28'h0, e_bank});
      wr(OFS_ACC, {24'h0, e_acc});
      adr = ea(r[9] & (i >= 4), f);
      m = mem[adr];
      res = r[10] ? m : e_acc | m;
      op({r[10] ? OPC_MOVE : OPC_OR_FILE, r[8], r[9] & (i >= 4), f});
      if (!r[8]) e_acc = res;
      e_flg = flg(res);
      chk("read addr", {20'h0, adr}, {20'h0, rd_addr});
      if (r[8]) begin
        chk("write addr", {20'h0, adr}, {20'h0, wr_addr});
        chk("written byte", {24'h0, res}, {24'h0, mem[adr]});
      end
      rdchk("acc", OFS_ACC, {24'h0, e_acc}); // result
      rdchk("status", OFS_STATUS, st(1'b0)); // file flags
    end
    give_verdict();
  end

endmodule : orm_core_tb

/* File: orm_exec.sv */
// Operand addressing and result logic of the OR, move and pointer-load unit.
`timescale 1ns/10ps

module orm_exec
  import orm_pkg::*;
(
  input  wire orm_dec_t    i_dec,
  input  wire logic [7:0]  i_acc,
  input  wire logic [3:0]  i_bank,
  input  wire logic [11:0] i_ptr2,
  input  wire logic        i_ext_en,
  input  wire logic [7:0]  i_rdata,
  output logic      [11:0] o_addr,
  output logic      [7:0]  o_result,
  output logic      [1:0]  o_flags
);

  // ==========================================================================
  // Address resolution
  // ==========================================================================
  // The bank selector wins when the origin bit is set; otherwise the low part
  // of the access bank may be remapped onto the third pointer's window.
  always_comb begin
    if (i_dec.bank_sel) begin
      o_addr = {i_bank, i_dec.faddr};
    end else if (i_ext_en && i_dec.faddr <= ACCESS_SPLIT) begin
      o_addr = i_ptr2 + {4'h0, i_dec.faddr};
    end else if (i_dec.faddr <= ACCESS_SPLIT) begin
      o_addr = {4'h0, i_dec.faddr};
    end else begin
      o_addr = {ACCESS_HIGH, i_dec.faddr};
    end
  end

  // ==========================================================================
  // Result and flags
  // ==========================================================================
  // Read data is only meaningful in the processing phase of file opcodes.
  always_comb begin
    unique case (i_dec.op)
      OP_IORL: o_result = i_acc | i_dec.faddr;
      OP_IORF: o_result = i_acc | i_rdata;
      OP_MOVE: o_result = i_rdata;
      default: o_result = 8'h00;
    endcase
  end

  assign o_flags = orm_flags(o_result);

endmodule : orm_exec

/* File: orm_pkg.sv */
// Shared constants, types and functions of the OR, move and pointer-load unit.
package orm_pkg;

  // ==========================================================================
  // Register map, byte addresses on the bus
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ACC    = 8'h0C;
  localparam logic [7:0] OFS_BANK   = 8'h10;
  localparam logic [7:0] OFS_PTR0   = 8'h14;
  localparam logic [7:0] OFS_PTR1   = 8'h18;
  localparam logic [7:0] OFS_PTR2   = 8'h1C;

  // Field positions.
  localparam int CTRL_EXT_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_WAIT_BIT  = 1;
  localparam int STAT_ZERO_BIT  = 2;
  localparam int STAT_SIGN_BIT  = 3;

  // Values after reset.
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [3:0] PHI_RST  = 4'h0;
  localparam logic [7:0] PLO_RST  = 8'h00;

  // ==========================================================================
  // Opcode patterns and addressing constants
  // ==========================================================================
  localparam logic [7:0] OPC_OR_LIT   = 8'h09;
  localparam logic [5:0] OPC_OR_FILE  = 6'h04;
  localparam logic [5:0] OPC_MOVE     = 6'h14;
  localparam logic [7:0] OPC_LDP_W1   = 8'hEE;
  localparam logic [1:0] OPC_LDP_PAD  = 2'h0;
  localparam logic [7:0] OPC_LDP_W2   = 8'hF0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;
  localparam logic [1:0] PTR_LAST     = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_Q1   = 3'h1,
    S_Q2   = 3'h3,
    S_Q3   = 3'h2,
    S_Q4   = 3'h6,
    S_WAIT = 3'h7
  } orm_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_IORL = 3'h1,
    OP_IORF = 3'h2,
    OP_MOVE = 3'h3,
    OP_LDP  = 3'h4
  } orm_op_t;

  typedef struct packed {
    orm_op_t    op;
    logic       dest;
    logic       bank_sel;
    logic [7:0] faddr;
    logic [1:0] pidx;
    logic [3:0] khi;
  } orm_dec_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } orm_mem_t;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Returns {sign, all_clear} for an eight-bit result.
  function automatic logic [1:0] orm_flags(input logic [7:0] r);
    orm_flags = {r[7], (r == 8'h00)};
  endfunction : orm_flags

  function automatic orm_dec_t orm_decode(input logic [15:0] w);
    orm_dec_t d;
    d.op       = OP_NONE;
    d.dest     = w[9];
    d.bank_sel = w[8];
    d.faddr    = w[7:0];
    d.pidx     = w[5:4];
    d.khi      = w[3:0];
    if (w[15:8] == OPC_OR_LIT) begin
      d.op = OP_IORL;
    end else if (w[15:10] == OPC_OR_FILE) begin
      d.op = OP_IORF;
    end else if (w[15:10] == OPC_MOVE) begin
      d.op = OP_MOVE;
    end else if (w[15:8] == OPC_LDP_W1 && w[7:6] == OPC_LDP_PAD) begin
      d.op = OP_LDP;
    end
    orm_decode = d;
  endfunction : orm_decode

endpackage : orm_pkg
